/* inc/eep_defs.svh */
`ifndef EEP_DEFS_SVH
`define EEP_DEFS_SVH

// Array geometry: 512 bytes, one select-code bit used as address bit 8
`define EEP_ADDR_W 9
`define EEP_DEPTH 512
`define EEP_UPPER_BITS 1
`define EEP_CE_ADDR_MASK 3'b001

// Page buffer geometry
`define EEP_PAGE_BYTES 16
`define EEP_PAGE_W 4

// Select code field positions
`define EEP_SEL_TYPE_MSB 7
`define EEP_SEL_TYPE_LSB 4
`define EEP_SEL_CE_MSB 3
`define EEP_SEL_CE_LSB 1
`define EEP_SEL_RW_BIT 0

// Bit counter values
`define EEP_BITS_PER_BYTE 4'h8
`define EEP_STOP_SLOT_BIT 4'h1

// Self-timed write cycle
`define EEP_TW_NS 5000000
`define EEP_MCLK_PERIOD_NS 25
`define EEP_TW_CNT_W 24

`endif

/* inc/eep_mem_if.sv */
`include "eep_defs.svh"

interface eep_mem_if;
    logic writeEn;
    logic [`EEP_ADDR_W-1:0] writeAddr;
    logic [7:0] writeData;
    logic [`EEP_ADDR_W-1:0] readAddr;
    logic [7:0] readData;

    modport ctrl
    (
        output writeEn,
        output writeAddr,
        output writeData,
        output readAddr,
        input readData
    );

    modport mem
    (
        input writeEn,
        input writeAddr,
        input writeData,
        input readAddr,
        output readData
    );
endinterface

/* inc/eep_pkg.sv */
package eep_pkg;

    typedef enum logic [4:0]
    {
        ST_IDLE   = 5'b00001,
        ST_SELECT = 5'b00010,
        ST_ADDR   = 5'b00100,
        ST_WDATA  = 5'b01000,
        ST_RDATA  = 5'b10000
    } eep_state_t;

    typedef logic [7:0] eep_byte_t;

endpackage

/* verif/eep_asserts.sv */
module eep_asserts
#(
    parameter int unsigned WRITE_CYCLES = 50
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic chipSelectStrap0,
    input wire logic chipSelectStrap1,
    input wire logic chipSelectStrap2,
    input wire logic writeProtectInput,
    input wire logic writeBusy
);
    timeunit 1ns;
    timeprecision 100ps;
    logic seenStart_reg;
    logic [7:0] sinceStop_reg;
    logic [31:0] busyLen_reg;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence startEv;
        scl && $fell(sdaIn);
    endsequence
    sequence stopEv;
        scl && $rose(sdaIn);
    endsequence
    // Raw bus events; the design sees them a few cycles later through its synchronisers
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seenStart_reg <= 1'b0;
            sinceStop_reg <= 8'hff;
            busyLen_reg <= 32'h0;
        end
        else
        begin
            seenStart_reg <= seenStart_reg | (scl & $fell(sdaIn));
            if (scl & $rose(sdaIn))
                sinceStop_reg <= 8'h00;
            else if (sinceStop_reg != 8'hff)
                sinceStop_reg <= sinceStop_reg + 8'h01;
            busyLen_reg <= writeBusy ? busyLen_reg + 32'h1 : 32'h0;
        end
    end
    a_out_low: assert property (sdaOut == 1'b0)
        else $error("sda driven high");
    a_busy_quiet: assert property (writeBusy |-> !sdaOe)
        else $error("sda driven while busy");
    a_before_start: assert property (!seenStart_reg |-> !sdaOe)
        else $error("sda driven before any start");
    a_oe_on_low: assert property ($changed(sdaOe) |-> !$past(scl, 3))
        else $error("sda changed outside clock low");
    a_oe_stands: assert property ($rose(scl) |-> $stable(sdaOe) [*4])
        else $error("sda changed while clock high");
    a_stop_release: assert property (stopEv |=> !sdaOe [*8])
        else $error("sda driven after stop");
    a_start_quiet: assert property (startEv |=> !sdaOe [*8])
        else $error("sda driven right after start");
    a_busy_after_stop: assert property ($rose(writeBusy) |-> sinceStop_reg <= 8'h08)
        else $error("write cycle without stop");
    a_busy_length: assert property ($fell(writeBusy) |->
        (busyLen_reg >= WRITE_CYCLES) && (busyLen_reg <= WRITE_CYCLES + 24))
        else $error("write cycle length wrong");
endmodule

bind eep_protocol eep_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_asserts
(
    .mclk(mclk),
    .rst_n(rst_n),
    .scl(scl),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .chipSelectStrap0(chipSelectStrap0),
    .chipSelectStrap1(chipSelectStrap1),
    .chipSelectStrap2(chipSelectStrap2),
    .writeProtectInput(writeProtectInput),
    .writeBusy(writeBusy)
);

/* verif/eep_master_model.sv */
module eep_master_model
(
    input wire logic mclk,
    input wire logic sdaBus,
    output logic scl,
    output logic sdaLow
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        scl = 1'b0;
        sdaLow = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Low phase of 6 cycles leaves room for the slave's late sda turn-round
    task automatic bitOut(input logic b);
        tick(2);
        sdaLow <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(2);
        scl <= 1'b0;
    endtask
    task automatic bitIn(output logic b);
        tick(2);
        sdaLow <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(1);
        b = sdaBus;
        tick(1);
        scl <= 1'b0;
    endtask
    task automatic start();
        tick(4);
        sdaLow <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sdaLow <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(2);
        sdaLow <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sdaLow <= 1'b0;
        tick(4);
    endtask
    // Fewer than 8 bits leaves the byte unfinished and unacknowledged
    task automatic putByte(input logic [7:0] b, input int n, output logic ack);
        logic nb;
        nb = 1'b1;
        for (int i = 7; i > 7 - n; i--)
            bitOut(b[i]);
        if (n == 8)
            bitIn(nb);
        ack = ~nb;
    endtask
    task automatic getByte(input logic more, output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            bitIn(b[i]);
        bitOut(!more);
    endtask
endmodule

/* verif/eep_protocol_tb.sv */
module eep_protocol_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import eep_pkg::*;
    logic mclk = 1'b0;
    logic rst_n;
    logic strap0;
    logic strap1;
    logic strap2;
    logic wp;
    logic scl;
    logic sdaLow;
    logic sdaOut;
    logic sdaOe;
    logic writeBusy;
    logic ack;
    eep_byte_t rdv;
    eep_byte_t mask[5] = '{8'h00, 8'h02, 8'h08, 8'h04, 8'h20};
    int n_fail = 0;
    int checks = 0;
    // Pulled-up open-drain wire
    wire logic sdaBus = !(sdaLow || (sdaOe && !sdaOut));
    always #12.5 mclk = ~mclk;
    eep_protocol #(.WRITE_CYCLES(50)) uut
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .scl(scl),
        .sdaIn(sdaBus),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .chipSelectStrap0(strap0),
        .chipSelectStrap1(strap1),
        .chipSelectStrap2(strap2),
        .writeProtectInput(wp),
        .writeBusy(writeBusy)
    );
    eep_master_model bm (.mclk(mclk), .sdaBus(sdaBus), .scl(scl), .sdaLow(sdaLow));
    task automatic finish_test();
        $display("checks %0d fails %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input eep_byte_t e, input eep_byte_t g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    function automatic eep_byte_t sel(input logic a8, input logic rw);
        return {4'h5, strap2, strap1, a8, rw};
    endfunction
    task automatic wrPage(input logic [8:0] a, input eep_byte_t d[$], input logic expAck);
        bm.start();
        bm.putByte(sel(a[8], 1'b0), 8, ack);
        chk("selw", 8'h01, {7'h0, ack});
        bm.putByte(a[7:0], 8, ack);
        chk("addr", 8'h01, {7'h0, ack});
        foreach (d[i])
        begin
            bm.putByte(d[i], 8, ack);
            chk("data", {7'h0, expAck}, {7'h0, ack});
        end
        bm.stop();
    endtask
    // A negative cut means a current-address read
    task automatic rdSeq(input logic [8:0] a, input int cut, input eep_byte_t e[$]);
        bm.start();
        if (cut >= 0)
        begin
            bm.putByte(sel(a[8], 1'b0), 8, ack);
            bm.putByte(a[7:0], 8, ack);
            if (cut > 0)
                bm.putByte(8'h00, cut, ack);
            bm.start();
        end
        bm.putByte(sel(a[8], 1'b1), 8, ack);
        chk("selr", 8'h01, {7'h0, ack});
        foreach (e[i])
        begin
            bm.getByte(i < e.size() - 1, rdv);
            chk("rd", e[i], rdv);
        end
        bm.stop();
    endtask
    task automatic poll();
        int k;
        k = 0;
        bm.tick(2);
        chk("busy", 8'h01, {7'h0, writeBusy});
        do
        begin
            bm.start();
            bm.putByte(sel(1'b0, 1'b0), 8, ack);
            k++;
        end
        while (!ack && k < 20);
        bm.stop();
        chk("poll", 8'h01, {7'h0, k > 1 && ack});
    endtask
    initial
    begin
        rst_n <= 1'b0;
        {strap2, strap1, strap0} <= 3'b100;
        wp <= 1'b0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        bm.tick(4);
        bm.putByte(sel(1'b1, 1'b0), 8, ack);
        chk("nostart", 8'h00, {7'h0, ack});
        wrPage(9'h10e, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66}, 1'b1);
        poll();
        wrPage(9'h1ff, '{8'h77}, 1'b1);
        poll();
        wrPage(9'h000, '{8'h88}, 1'b1);
        poll();
        $display("test write done");
        rdSeq(9'h10e, 0, '{8'h11});
        rdSeq(9'h10f, -1, '{8'h22});
        rdSeq(9'h100, 3, '{8'h33, 8'h44, 8'h55});
        rdSeq(9'h103, -1, '{8'h66});
        rdSeq(9'h1ff, 0, '{8'h77, 8'h88});
        $display("test read done");
        for (int p = 0; p < 2; p++)
        begin
            {strap2, strap1, strap0} <= p ? 3'b011 : 3'b100;
            bm.tick(8);
            foreach (mask[i])
            begin
                bm.start();
                bm.putByte(sel(1'b0, 1'b0) ^ mask[i], 8, ack);
                bm.stop();
                chk("select", {7'h0, mask[i] < 8'h04}, {7'h0, ack});
            end
        end
        $display("test select done");
        wp <= 1'b1;
        wrPage(9'h000, '{8'hc3}, 1'b0);
        wp <= 1'b0;
        bm.tick(8);
        chk("wpbusy", 8'h00, {7'h0, writeBusy});
        bm.start();
        bm.putByte(sel(1'b0, 1'b0), 8, ack);
        bm.putByte(8'h00, 8, ack);
        bm.putByte(8'h5a, 8, ack);
        chk("lateack", 8'h01, {7'h0, ack});
        bm.putByte(8'ha5, 4, ack);
        bm.stop();
        bm.tick(8);
        chk("latestop", 8'h00, {7'h0, writeBusy});
        rdSeq(9'h000, 0, '{8'h88});
        $display("test protect done");
        finish_test();
    end
    // The run needs well under half a millisecond
    initial
    begin
        #1000000;
        n_fail++;
        finish_test();
    end
endmodule

/* verilog/eep_array.sv */
`include "eep_defs.svh"

module eep_array
(
    input wire logic mclk,
    eep_mem_if.mem port
);
    logic [7:0] cells [0:`EEP_DEPTH-1];
    logic [7:0] readData_reg;

    // No reset on the cells: contents survive a reset of the protocol engine
    always_ff @(posedge mclk)
    begin
        if (port.writeEn)
        begin
            cells[port.writeAddr] <= port.writeData;
        end
        readData_reg <= cells[port.readAddr];
    end

    assign port.readData = readData_reg;
endmodule

/* verilog/eep_protocol.sv */
`include "eep_defs.svh"

// Behaviour
// - Start: data falls while clock high
// - Watch for Start; ignore bus until then
// - Stop: data rises with clock high; ends transfer
// - Release after eight bits; receiver acks ninth
// - Sample data on rising clock edge
// - Select: type, chip enables, direction, MSB first
// - Respond only if chip enables match straps
// - Address-bit positions skip strap comparison
// - Eighth select bit: one read, zero write
// - Ack match in ninth bit; mismatch goes standby
// - Write select, then acked address, then data
// - Program only on Stop in tenth slot
// - Ignore bus during internal write cycle
// - Busy polling gets no ack until done
// - Write protect: ack select/address, nack data
// - Page of 16 bytes; low 4 bits wrap
// - Random read: dummy write, restart, read select
// - Current read outputs counter byte, then increments
// - Acked reads continue; counter wraps to zero
// - Master nack ends read, device to standby
module eep_protocol
#(
    parameter logic [3:0] DEV_TYPE = 4'h5,
    parameter int unsigned WRITE_CYCLES = `EEP_TW_NS / `EEP_MCLK_PERIOD_NS
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic chipSelectStrap0,
    input wire logic chipSelectStrap1,
    input wire logic chipSelectStrap2,
    input wire logic writeProtectInput,
    output logic writeBusy
);
    import eep_pkg::*;

    // DEV_TYPE default is arbitrary; set it to the device type identifier in use

    typedef struct packed
    {
        logic sclS1;
        logic sclS2;
        logic sclD;
        logic sdaS1;
        logic sdaS2;
        logic sdaD;
        logic [2:0] strapS1;
        logic [2:0] strapS2;
        logic wpS1;
        logic wpS2;
        eep_state_t st;
        logic prog;
        logic [4:0] progStep;
        logic [`EEP_TW_CNT_W-1:0] waitCnt;
        logic [3:0] bitCnt;
        logic ackSlot;
        logic lastAck;
        logic wpSeen;
        eep_byte_t rxByte;
        eep_byte_t txByte;
        logic [`EEP_ADDR_W-1:0] addrCnt;
        logic [`EEP_PAGE_BYTES-1:0][7:0] pageData;
        logic [`EEP_PAGE_BYTES-1:0] pageValid;
        logic oe;
        logic busy;
    } eep_core_t;

    eep_core_t r_reg;
    eep_core_t r_next;

    eep_mem_if memBus();

    eep_array uArray
    (
        .mclk(mclk),
        .port(memBus.mem)
    );

    logic sclRise;
    logic sclFall;
    logic startEv;
    logic stopEv;
    logic selTypeOk;
    logic selCeOk;
    eep_byte_t shifted;

    assign sclRise = r_reg.sclS2 & ~r_reg.sclD;
    assign sclFall = ~r_reg.sclS2 & r_reg.sclD;
    assign startEv = r_reg.sclS2 & r_reg.sclD & r_reg.sdaD & ~r_reg.sdaS2;
    assign stopEv = r_reg.sclS2 & r_reg.sclD & ~r_reg.sdaD & r_reg.sdaS2;
    assign shifted = {r_reg.rxByte[6:0], r_reg.sdaS2};

    // Decoded from the completed select byte at the eighth falling edge
    assign selTypeOk = r_reg.rxByte[`EEP_SEL_TYPE_MSB:`EEP_SEL_TYPE_LSB] == DEV_TYPE;
    assign selCeOk = ((r_reg.rxByte[`EEP_SEL_CE_MSB:`EEP_SEL_CE_LSB] ^ r_reg.strapS2)
        & ~`EEP_CE_ADDR_MASK) == 3'h0;

    assign memBus.writeEn = r_reg.prog && !r_reg.progStep[4]
        && r_reg.pageValid[r_reg.progStep[3:0]];
    assign memBus.writeAddr = {r_reg.addrCnt[`EEP_ADDR_W-1:`EEP_PAGE_W], r_reg.progStep[3:0]};
    assign memBus.writeData = r_reg.pageData[r_reg.progStep[3:0]];
    // Read port follows the counter every cycle, so data is ready long before the SCL edge
    assign memBus.readAddr = r_reg.addrCnt;

    always_comb
    begin
        r_next = r_reg;
        r_next.sclS1 = scl;
        r_next.sclS2 = r_reg.sclS1;
        r_next.sclD = r_reg.sclS2;
        r_next.sdaS1 = sdaIn;
        r_next.sdaS2 = r_reg.sdaS1;
        r_next.sdaD = r_reg.sdaS2;
        r_next.strapS1 = {chipSelectStrap2, chipSelectStrap1, chipSelectStrap0};
        r_next.strapS2 = r_reg.strapS1;
        r_next.wpS1 = writeProtectInput;
        r_next.wpS2 = r_reg.wpS1;

        if (r_reg.prog)
        begin
            // Bus lines are not looked at here, so polls go unanswered
            r_next.oe = 1'b0;
            if (!r_reg.progStep[4])
            begin
                r_next.progStep = r_reg.progStep + 5'h01;
            end
            else if (r_reg.waitCnt == `EEP_TW_CNT_W'(WRITE_CYCLES - 1))
            begin
                r_next.prog = 1'b0;
                r_next.pageValid = '0;
                r_next.st = ST_IDLE;
            end
            else
            begin
                r_next.waitCnt = r_reg.waitCnt + `EEP_TW_CNT_W'(1);
            end
        end
        else if (startEv)
        begin
            // A repeated Start drops any half-received byte and pending page data
            r_next.st = ST_SELECT;
            r_next.bitCnt = 4'h0;
            r_next.ackSlot = 1'b0;
            r_next.lastAck = 1'b0;
            r_next.oe = 1'b0;
            r_next.wpSeen = r_reg.wpS2;
            r_next.pageValid = '0;
        end
        else if (stopEv)
        begin
            r_next.oe = 1'b0;
            r_next.ackSlot = 1'b0;
            r_next.st = ST_IDLE;
            if (r_reg.st == ST_WDATA && r_reg.bitCnt == `EEP_STOP_SLOT_BIT && r_reg.lastAck
                && !r_reg.ackSlot && r_reg.pageValid != '0)
            begin
                r_next.prog = 1'b1;
                r_next.progStep = 5'h00;
                r_next.waitCnt = '0;
            end
        end
        else
        begin
            if (r_reg.st == ST_SELECT || r_reg.st == ST_ADDR)
            begin
                r_next.wpSeen = r_reg.wpSeen | r_reg.wpS2;
            end
            unique case (r_reg.st)
                ST_IDLE:
                begin
                    r_next.oe = 1'b0;
                end
                ST_SELECT, ST_ADDR, ST_WDATA:
                begin
                    if (sclRise && !r_reg.ackSlot && r_reg.bitCnt != `EEP_BITS_PER_BYTE)
                    begin
                        r_next.rxByte = shifted;
                        r_next.bitCnt = r_reg.bitCnt + 4'h1;
                        if (r_reg.bitCnt != 4'h0)
                        begin
                            r_next.lastAck = 1'b0;
                        end
                    end
                    else if (sclFall && r_reg.ackSlot)
                    begin
                        r_next.oe = 1'b0;
                        r_next.ackSlot = 1'b0;
                        r_next.bitCnt = 4'h0;
                    end
                    else if (sclFall && r_reg.bitCnt == `EEP_BITS_PER_BYTE)
                    begin
                        r_next.ackSlot = 1'b1;
                        if (r_reg.st == ST_SELECT)
                        begin
                            if (selTypeOk && selCeOk)
                            begin
                                r_next.oe = 1'b1;
                                r_next.addrCnt[`EEP_ADDR_W-1:8] =
                                    r_reg.rxByte[`EEP_UPPER_BITS:1];
                                if (r_reg.rxByte[`EEP_SEL_RW_BIT])
                                begin
                                    r_next.st = ST_RDATA;
                                end
                                else
                                begin
                                    r_next.st = ST_ADDR;
                                end
                            end
                            else
                            begin
                                r_next.ackSlot = 1'b0;
                                r_next.st = ST_IDLE;
                            end
                        end
                        else if (r_reg.st == ST_ADDR)
                        begin
                            r_next.oe = 1'b1;
                            r_next.addrCnt[7:0] = r_reg.rxByte;
                            r_next.st = ST_WDATA;
                        end
                        else if (!r_reg.wpSeen)
                        begin
                            r_next.oe = 1'b1;
                            r_next.lastAck = 1'b1;
                            r_next.pageData[r_reg.addrCnt[3:0]] = r_reg.rxByte;
                            r_next.pageValid[r_reg.addrCnt[3:0]] = 1'b1;
                            r_next.addrCnt[3:0] = r_reg.addrCnt[3:0] + 4'h1;
                        end
                        else
                        begin
                            r_next.oe = 1'b0;
                            r_next.lastAck = 1'b0;
                        end
                    end
                end
                ST_RDATA:
                begin
                    if (sclRise)
                    begin
                        if (r_reg.ackSlot)
                        begin
                            if (r_reg.sdaS2)
                            begin
                                r_next.ackSlot = 1'b0;
                                r_next.oe = 1'b0;
                                r_next.st = ST_IDLE;
                            end
                        end
                        else
                        begin
                            r_next.bitCnt = r_reg.bitCnt + 4'h1;
                        end
                    end
                    else if (sclFall)
                    begin
                        if (r_reg.ackSlot)
                        begin
                            // Ack slot of the select or of the master: load next byte
                            r_next.ackSlot = 1'b0;
                            r_next.bitCnt = 4'h0;
                            r_next.txByte = memBus.readData;
                            r_next.oe = ~memBus.readData[7];
                            r_next.addrCnt = r_reg.addrCnt + `EEP_ADDR_W'(1);
                        end
                        else if (r_reg.bitCnt == `EEP_BITS_PER_BYTE)
                        begin
                            r_next.oe = 1'b0;
                            r_next.ackSlot = 1'b1;
                        end
                        else if (r_reg.bitCnt != 4'h0)
                        begin
                            r_next.txByte = {r_reg.txByte[6:0], 1'b0};
                            r_next.oe = ~r_reg.txByte[6];
                        end
                    end
                end
                default:
                begin
                    r_next.oe = 1'b0;
                    r_next.st = ST_IDLE;
                end
            endcase
        end
        r_next.busy = r_next.prog;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= '{
                st: ST_IDLE,
                sclS1: 1'b1, sclS2: 1'b1, sclD: 1'b1,
                sdaS1: 1'b1, sdaS2: 1'b1, sdaD: 1'b1,
                default: '0
            };
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sdaOut <= 1'b0;
        end
        else
        begin
            sdaOut <= 1'b0;
        end
    end

    assign sdaOe = r_reg.oe;
    assign writeBusy = r_reg.busy;
endmodule
